/* File: pkg/ivc_pkg.sv */
// constants, types and vector map for the interrupt vector controller
// assumes one system clock and a synchronous, active-high device reset
// Notes on behaviour
// [R1] all requests merge into one core request
// [R2] seven user levels, ties by natural order
// [R3] every source owns its own vector
// [R4] fixed entry latency, independent of source
// [R5] primary table at 000004h, 126 vectors
// [R6] each vector supplies a 24-bit routine address
// [R7] lower vector number wins natural priority
// [R8] 21 sources and 4 traps implemented
// [R9] select bit 15 moves fetches to alternate
// [R10] alternate address equals primary plus 0x100
// [R11] software fills unused alternate with primary
// [R12] reset bypasses controller, start at zero
// [R13] software points unused slots at default handler
// [R14] request n is vector n+8, 0x14+2n
// [R15] external lines 1 and 2 at 20, 29
// [R16] timer and capture sources at listed numbers
// [R17] serial and converter sources at listed numbers
// [R18] flag, enable, priority laid out by number
// [R19] eight levels per source, zero disables
// [R20] reserved request numbers tied inactive
// [R21] highest level first, lowest number ties
`default_nettype none
package ivc_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // table geometry
  localparam int          IVC_NUM_IRQ      = 118;          // request slots
  localparam int          IVC_NUM_TRAP     = 8;            // trap slots
  localparam int          IVC_IRQ_W        = 7;            // request number width
  localparam int          IVC_ADDR_W       = 24;           // program address width
  localparam logic [23:0] IVC_PRI_BASE     = 24'h000004;   // primary table start
  localparam logic [23:0] IVC_ALT_OFS      = 24'h000100;   // alternate table offset
  localparam logic [23:0] IVC_RESET_ADDR   = 24'h000000;   // reset entry
  localparam logic [6:0]  IVC_VEC_OFS      = 7'h08;        // request to vector offset
  localparam int          IVC_ALT_SEL_BIT  = 15;           // select bit in control two
  localparam int          IVC_ENTRY_LAT    = 2;            // fixed entry latency
  localparam logic [2:0]  IVC_LVL_OFF      = 3'h0;         // level 0 never taken

  ////////////////////////////////////////////////////////////////////////////
  // request numbers of implemented sources
  localparam int IRQ_EXT0   = 0;
  localparam int IRQ_CAP1   = 1;    // R16
  localparam int IRQ_CMP1   = 2;
  localparam int IRQ_TMR1   = 3;
  localparam int IRQ_CAP2   = 5;
  localparam int IRQ_CMP2   = 6;
  localparam int IRQ_TMR2   = 7;
  localparam int IRQ_TMR3   = 8;
  localparam int IRQ_SPIERR = 9;    // R17
  localparam int IRQ_SPIDN  = 10;
  localparam int IRQ_RX     = 11;
  localparam int IRQ_TX     = 12;
  localparam int IRQ_CONV   = 13;
  localparam int IRQ_TWSLV  = 16;
  localparam int IRQ_TWMST  = 17;
  localparam int IRQ_PCN    = 19;
  localparam int IRQ_EXT1   = 20;   // R15
  localparam int IRQ_CAP7   = 22;
  localparam int IRQ_CAP8   = 23;
  localparam int IRQ_EXT2   = 29;   // R15
  localparam int IRQ_UERR   = 65;

  // implemented request slots, one bit per request number
  localparam logic [117:0] IVC_IMPL_MASK =
    (118'h1 << IRQ_EXT0) | (118'h1 << IRQ_CAP1) | (118'h1 << IRQ_CMP1) |
    (118'h1 << IRQ_TMR1) | (118'h1 << IRQ_CAP2) | (118'h1 << IRQ_CMP2) |
    (118'h1 << IRQ_TMR2) | (118'h1 << IRQ_TMR3) | (118'h1 << IRQ_SPIERR) |
    (118'h1 << IRQ_SPIDN) | (118'h1 << IRQ_RX) | (118'h1 << IRQ_TX) |
    (118'h1 << IRQ_CONV) | (118'h1 << IRQ_TWSLV) | (118'h1 << IRQ_TWMST) |
    (118'h1 << IRQ_PCN) | (118'h1 << IRQ_EXT1) | (118'h1 << IRQ_CAP7) |
    (118'h1 << IRQ_CAP8) | (118'h1 << IRQ_EXT2) | (118'h1 << IRQ_UERR);

  // trap slots 1..4 implemented
  localparam logic [7:0] IVC_TRAP_MASK = 8'h1e;

  // arbitration state
  typedef enum logic [1:0] {IVC_IDLE, IVC_FETCH, IVC_ACTIVE} ivc_state_t;
endpackage : ivc_pkg
`default_nettype wire

/* File: core/ivc_controller.sv */
// interrupt vector controller: arbitration and vector address generation
// assumes synchronous request levels, core acknowledges with a pulse
`default_nettype none
module ivc_controller
  import ivc_pkg::*;
#(
  parameter int NUM_IRQ = IVC_NUM_IRQ
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // request side: flags, enables, levels in request order
  input  wire logic [NUM_IRQ-1:0]    irq_flag,
  input  wire logic [NUM_IRQ-1:0]    irq_enable,
  input  wire logic [3*NUM_IRQ-1:0]  irq_level,
  input  wire logic [7:0]            trap_req,
  // control register two image
  input  wire logic [15:0]           interrupt_control_two,
  // current core level, 4 bits (traps above 7)
  input  wire logic [3:0]            cpu_level,
  // core side
  output logic                       core_irq,
  output logic [6:0]                 vec_num,
  output logic [3:0]                 vec_level,
  output logic [23:0]                vec_addr,
  output logic                       vec_valid,
  input  wire logic                  core_ack,
  input  wire logic                  core_return,
  // reset entry
  output logic [23:0]                reset_pc
);

  // elaboration check: the implemented mask is sized for the full request table
  if (NUM_IRQ != IVC_NUM_IRQ) begin : g_bad_num_irq
    $error("ivc: NUM_IRQ must be 118");
  end

  ////////////////////////////////////////////////////////////////////////////
  // masking of reserved slots
  // reserved numbers are gated here, not at the sources, so a stray flag
  // from an unused peripheral slot can never take part in arbitration
  // traps outside the implemented set are dropped the same way
  // flags and enables line up bit for bit with request numbers
  logic [NUM_IRQ-1:0] live;        // pending, enabled, implemented
  logic [7:0]         trap_live;   // implemented traps only
  assign live      = irq_flag & irq_enable & IVC_IMPL_MASK;  // R20 R18
  assign trap_live = trap_req & IVC_TRAP_MASK;               // R8

  ////////////////////////////////////////////////////////////////////////////
  // combinational winner search: level first, then lowest number
  // one long priority chain over all request slots; it costs depth, but
  // keeps the answer ready in the same cycle the core acknowledges
  // a pipelined tree would shorten the path at the price of a stale winner
  // the result only matters while idle, since it is latched at acceptance
  // level zero is treated as disabled and never enters the compare
  // traps are scanned first and block every user level afterwards
  logic [6:0] best_vec;   // winning vector number
  logic [3:0] best_lvl;   // winning level
  logic       best_any;   // a candidate exists
  always_comb begin
    logic [2:0] lv;
    lv       = 3'h0;
    best_vec = 7'h00;
    best_lvl = 4'h0;
    best_any = 1'b0;
    // traps beat every user level, lowest trap first
    for (int t = IVC_NUM_TRAP - 1; t >= 0; t--) begin  // R7
      if (trap_live[t]) begin
        best_vec = 7'(t);
        best_lvl = 4'h8;
        best_any = 1'b1;
      end
    end
    // scan high to low number so equal levels keep the lower one
    for (int n = NUM_IRQ - 1; n >= 0; n--) begin  // R2 R21
      lv = irq_level[3*n +: 3];
      if (live[n] && lv != IVC_LVL_OFF && {1'b0, lv} >= best_lvl &&  // R19
          !(best_lvl == 4'h8)) begin
        best_vec = 7'(n) + IVC_VEC_OFS;  // R14 R3
        best_lvl = {1'b0, lv};
        best_any = 1'b1;
      end
    end
  end

  // request only when the winner beats the running level
  // equal level does not interrupt: the core must finish what it runs
  // traps at level 8 still pass a core running at level 7
  logic req_now;
  assign req_now = best_any && (best_lvl > cpu_level);  // R1

  ////////////////////////////////////////////////////////////////////////////
  // vector address: base + 2*vector, plus alternate offset
  // each entry is two address units wide, hence the shift by one
  // the alternate offset never carries past bit 8 for any legal vector
  // so both tables share every low address bit
  function automatic logic [23:0] vec_to_addr(input logic [6:0] v, input logic alt);
    logic [23:0] a;
    a = IVC_PRI_BASE + {16'h0000, v, 1'b0};  // R5 R6
    if (alt) begin
      a = a + IVC_ALT_OFS;  // R10
    end
    return a;
  endfunction : vec_to_addr

  ////////////////////////////////////////////////////////////////////////////
  // entry sequencer: fixed latency from ack to vector valid
  // the countdown does not depend on the winner, its level or the table,
  // so every source sees the same number of cycles before its vector
  // acknowledges outside idle are ignored; the core must wait for return
  // the return pulse is only honoured once the vector has been presented
  // a stuck encoding falls back to idle through the default branch
  ivc_state_t state_r;
  logic [1:0] lat_r;    // entry latency counter
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= IVC_IDLE;
      lat_r   <= 2'h0;
    end else begin
      case (state_r)
        IVC_IDLE: begin
          if (req_now && core_ack) begin
            state_r <= IVC_FETCH;
            lat_r   <= 2'(IVC_ENTRY_LAT - 1);
          end
        end
        IVC_FETCH: begin  // R4
          if (lat_r == 2'h0) begin
            state_r <= IVC_ACTIVE;
          end else begin
            lat_r <= lat_r - 2'h1;
          end
        end
        IVC_ACTIVE: begin
          if (core_return) begin
            state_r <= IVC_IDLE;
          end
        end
        default: state_r <= IVC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latch the winner at acknowledge so the vector cannot change mid entry
  // the select bit is sampled here as well: flipping it during a service
  // only affects the next acceptance, never the vector in flight
  // after reset the address shows the fixed start entry
  always_ff @(posedge clk) begin
    if (reset) begin
      vec_num   <= 7'h00;
      vec_level <= 4'h0;
      vec_addr  <= IVC_RESET_ADDR;  // R12
    end else if (state_r == IVC_IDLE && req_now && core_ack) begin
      vec_num   <= best_vec;
      vec_level <= best_lvl;
      vec_addr  <= vec_to_addr(best_vec, interrupt_control_two[IVC_ALT_SEL_BIT]);  // R9
    end
  end

  // request level stands while idle and a winner outranks the core
  // it drops as soon as the entry starts, so the core sees one request
  // per acceptance and cannot acknowledge twice
  assign core_irq  = (state_r == IVC_IDLE) && req_now;  // R1
  assign vec_valid = (state_r == IVC_ACTIVE);
  // reset never passes the arbiter: start address is fixed
  assign reset_pc  = IVC_RESET_ADDR;  // R12

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  // shadow copy of the winner at acceptance, used only by the checks
  // below to compare against what the core is finally shown
  logic [6:0] cap_vec_q;   // winner seen at acceptance
  logic [3:0] cap_lvl_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      cap_vec_q <= 7'h00;
      cap_lvl_q <= 4'h0;
    end else if (state_r == IVC_IDLE && core_irq && core_ack) begin
      cap_vec_q <= best_vec;
      cap_lvl_q <= best_lvl;
    end
  end

  fixed_entry_a: assert property (@(posedge clk) disable iff (reset)  // R4
    core_irq && core_ack |-> !vec_valid ##1 !vec_valid ##1 !vec_valid ##1 vec_valid)
    else $error("entry latency not fixed");
  single_request_a: assert property (@(posedge clk) disable iff (reset)  // R1
    core_irq |-> best_any && best_lvl > cpu_level)
    else $error("request without qualifying source");
  alt_address_a: assert property (@(posedge clk) disable iff (reset)  // R10
    vec_valid && interrupt_control_two[IVC_ALT_SEL_BIT] && $stable(interrupt_control_two)
      && vec_num >= IVC_VEC_OFS |-> vec_addr[8] == 1'b1 || vec_addr >= 24'h000104)
    else $error("alternate address wrong");
  irq_map_a: assert property (@(posedge clk) disable iff (reset)  // R14
    $rose(vec_valid) && vec_level != 4'h8 |->
      vec_addr[7:0] == 8'(IVC_PRI_BASE + {17'h0, vec_num, 1'b0}))
    else $error("vector address not 0x14 + 2n");
  reserved_quiet_a: assert property (@(posedge clk) disable iff (reset)  // R20
    (irq_flag & IVC_IMPL_MASK) == '0 && trap_live == 8'h0 |-> !core_irq)
    else $error("reserved slot raised request");
  level_zero_a: assert property (@(posedge clk) disable iff (reset)  // R19
    core_irq && trap_live == 8'h0 |-> best_lvl != 4'h0)
    else $error("level zero source taken");
  vector_stable_a: assert property (@(posedge clk) disable iff (reset)  // R3
    $rose(vec_valid) |-> vec_num == cap_vec_q && vec_level == cap_lvl_q)
    else $error("vector changed during entry");
  trap_first_a: assert property (@(posedge clk) disable iff (reset)  // R7
    trap_live != 8'h0 && core_irq |-> best_vec < IVC_VEC_OFS)
    else $error("trap not ranked first");
  reset_entry_a: assert property (@(posedge clk)  // R12
    reset |=> vec_addr == IVC_RESET_ADDR && !vec_valid)
    else $error("reset entry not zero");

  ////////////////////////////////////////////////////////////////////////////
  // further checks on the core side: what the core may rely on between
  // acceptance and return, and how the latched vector relates to the table
  // these watch outputs and internal state, plus the core's ack and return, the cpu level and control register two inputs

  // no new request while an entry or a service is in progress
  busy_quiet_a: assert property (@(posedge clk) disable iff (reset)  // R1
    state_r != IVC_IDLE |-> !core_irq)
    else $error("request raised while busy");

  // the vector stays valid until the core says it is done
  valid_held_a: assert property (@(posedge clk) disable iff (reset)  // R4
    vec_valid && !core_return |=> vec_valid)
    else $error("vector valid dropped early");

  // a return ends the service on the next edge
  return_ends_a: assert property (@(posedge clk) disable iff (reset)  // R4
    vec_valid && core_return |=> !vec_valid)
    else $error("vector valid outlived return");

  // the vector is only presented after the fetch countdown
  fetch_first_a: assert property (@(posedge clk) disable iff (reset)  // R4
    $rose(vec_valid) |-> $past(state_r) == IVC_FETCH)
    else $error("vector valid without fetch");

  // the latched vector does not move while it is being served
  vector_hold_a: assert property (@(posedge clk) disable iff (reset)  // R3
    vec_valid && $past(vec_valid) |-> $stable(vec_addr) && $stable(vec_num))
    else $error("vector moved during service");

  // a trap vector always carries the trap level
  trap_level_a: assert property (@(posedge clk) disable iff (reset)  // R7
    $rose(vec_valid) && vec_num < IVC_VEC_OFS |-> vec_level == 4'h8)
    else $error("trap vector without trap level");

  // a user vector never lands inside the trap slots
  user_vector_a: assert property (@(posedge clk) disable iff (reset)  // R14
    $rose(vec_valid) && vec_level != 4'h8 |-> vec_num >= IVC_VEC_OFS)
    else $error("user vector inside trap slots");

  // a user vector carries one of the seven live levels
  user_level_a: assert property (@(posedge clk) disable iff (reset)  // R19
    $rose(vec_valid) && vec_level != 4'h8 |-> vec_level != 4'h0 && vec_level <= 4'h7)
    else $error("user level out of range");

  // every vector address is word aligned
  addr_align_a: assert property (@(posedge clk) disable iff (reset)  // R6
    $rose(vec_valid) |-> (vec_addr & 24'h000001) == 24'h000000)
    else $error("vector address not aligned");

  // the taken level outranks the level the core ran at acceptance
  outrank_a: assert property (@(posedge clk) disable iff (reset)  // R21
    state_r == IVC_IDLE && core_irq && core_ack |=> vec_level > $past(cpu_level))
    else $error("taken level not above core level");

  // select bit set at acceptance picks the alternate table, primary plus 0x100
  alt_select_a: assert property (@(posedge clk) disable iff (reset)  // R9
    core_irq && core_ack && interrupt_control_two[IVC_ALT_SEL_BIT]
      |=> (vec_addr & IVC_ALT_OFS) != 24'h000000)
    else $error("alternate table not used");

  // select bit clear keeps every vector inside the primary table
  primary_select_a: assert property (@(posedge clk) disable iff (reset)  // R5
    core_irq && core_ack && !interrupt_control_two[IVC_ALT_SEL_BIT]
      |=> (vec_addr & IVC_ALT_OFS) == 24'h000000 && vec_addr >= IVC_PRI_BASE)
    else $error("primary vector outside table");

  // only implemented traps can win
  trap_impl_a: assert property (@(posedge clk) disable iff (reset)  // R8
    core_irq && best_lvl == 4'h8 |-> IVC_TRAP_MASK[best_vec[2:0]])
    else $error("unimplemented trap won");

  ////////////////////////////////////////////////////////////////////////////
  // coverage of the main scenarios: plain entry, alternate table, traps,
  // return, and a request that outranks a busy core level
  entry_seen_c: cover property (@(posedge clk) disable iff (reset) $rose(vec_valid));
  alt_seen_c: cover property (@(posedge clk) disable iff (reset)
    $rose(vec_valid) && interrupt_control_two[IVC_ALT_SEL_BIT]);
  trap_seen_c: cover property (@(posedge clk) disable iff (reset)
    core_irq && best_lvl == 4'h8);
  return_seen_c: cover property (@(posedge clk) disable iff (reset)
    vec_valid && core_return);
  nested_seen_c: cover property (@(posedge clk) disable iff (reset)
    core_irq && core_ack && cpu_level != 4'h0);

endmodule : ivc_controller
`default_nettype wire

/* File: sim/ivc_core_model.sv */
// core-side model: takes a raised request, serves it, then returns
// assumes one clock and a synchronous, active-high reset
`default_nettype none
module ivc_core_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // controller side
  input  wire logic       core_irq,
  input  wire logic       vec_valid,
  output logic            core_ack,
  output logic            core_return,
  // service time in cycles, so prompt and slow cores can be tried
  input  wire logic [3:0] hold
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy_r;  // between ack and return
  logic [3:0] cnt_r;   // service cycles so far
  //////////////////////////////////////////////////////////////////////////
  // one-cycle ack, then one return pulse after hold plus one cycles of service
  always_ff @(posedge clk) begin
    core_ack    <= 1'b0;
    core_return <= 1'b0;
    if (reset) begin
      busy_r <= 1'b0;
      cnt_r  <= 4'h0;
    end else if (!busy_r && core_irq) begin
      core_ack <= 1'b1;
      busy_r   <= 1'b1;
    end else if (busy_r && vec_valid) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == hold) begin
        core_return <= 1'b1;
        busy_r      <= 1'b0;
        cnt_r       <= 4'h0;
      end
    end
  end
endmodule : ivc_core_model
`default_nettype wire

/* File: sim/test_interrupt_vector_controller.sv */
// bench for the vector controller with a core model on its far side
// assumes the package constants and a 40 ns system clock
`default_nettype none
module test_interrupt_vector_controller;
  import ivc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, core_irq, vec_valid, core_ack, core_return;
  logic [117:0] irq_flag = '0, irq_enable = '0;
  logic [353:0] irq_level = '0;
  logic [7:0]   trap_req = 8'h00;
  logic [15:0]  interrupt_control_two = 16'h0000;
  logic [3:0]   cpu_level = 4'h0, vec_level, hold = 4'h0;
  logic [6:0]   vec_num;
  logic [23:0]  vec_addr, reset_pc;
  int n_fail = 0, num_checks = 0;
  int srcs[21] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 12, 13, 16, 17, 19, 20, 22, 23, 29, 65};
  always #20 clk = ~clk;
  ivc_controller ivc_controller_inst (.clk(clk), .reset(reset), .irq_flag(irq_flag),
    .irq_enable(irq_enable), .irq_level(irq_level), .trap_req(trap_req),
    .interrupt_control_two(interrupt_control_two), .cpu_level(cpu_level),
    .core_irq(core_irq), .vec_num(vec_num), .vec_level(vec_level), .vec_addr(vec_addr),
    .vec_valid(vec_valid), .core_ack(core_ack), .core_return(core_return),
    .reset_pc(reset_pc));
  ivc_core_model ivc_core_model_inst (.clk(clk), .reset(reset), .core_irq(core_irq),
    .vec_valid(vec_valid), .core_ack(core_ack), .core_return(core_return), .hold(hold));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // request n pending and enabled at a level; caller sits on a rising edge
  task automatic setreq(input int n, input logic [2:0] lvl);
    irq_flag[n]         <= 1'b1;
    irq_enable[n]       <= 1'b1;
    irq_level[3*n +: 3] <= lvl;
  endtask : setreq
  // wait for acceptance, time the entry, check the vector, clear, wait out service
  task automatic take(input logic [6:0] en, input logic [23:0] ea);
    int k;
    k = 0;
    while (!(core_ack === 1'b1 && core_irq === 1'b1) && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk("ack seen", k < 40, 1'b1);
    k = 0;
    while (vec_valid !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk("entry latency", k, 3);
    chk("vec_num", vec_num, en);
    chk("vec_addr", vec_addr, ea);
    @(posedge clk);
    irq_flag <= '0;
    trap_req <= 8'h00;
    k = 0;
    while (vec_valid !== 1'b0 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk("return seen", k < 40, 1'b1);
  endtask : take
  // no request may reach the core for a while, then clear all flags and trap requests
  task automatic quiet(input string what);
    repeat (4) begin
      @(negedge clk);
      chk(what, core_irq, 1'b0);
    end
    @(posedge clk);
    irq_flag <= '0;
    trap_req <= 8'h00;
  endtask : quiet
  //////////////////////////////////////////////////////////////////////////
  task automatic t_map;
    foreach (srcs[i]) begin
      @(posedge clk);
      hold <= 4'(i % 3);  // prompt and slow service alike
      setreq(srcs[i], 3'h1);
      take(7'(srcs[i] + 8), 24'h000014 + 24'(2 * srcs[i]));
    end
    $display("map test done");
  endtask : t_map
  task automatic t_prio;
    @(posedge clk);
    setreq(3, 3'h2);
    setreq(29, 3'h5);
    setreq(20, 3'h5);
    take(7'h1c, 24'h00003c);
    chk("vec_level", vec_level, 4'h5);
    @(posedge clk);
    setreq(3, 3'h4);
    setreq(1, 3'h4);
    take(7'h09, 24'h000016);
    @(posedge clk);
    cpu_level <= 4'h3;
    setreq(9, 3'h3);
    quiet("core_irq at cpu level");
    @(posedge clk);
    setreq(9, 3'h4);
    take(7'h11, 24'h000026);
    @(posedge clk);
    cpu_level <= 4'h0;
    setreq(13, 3'h0);
    setreq(4, 3'h7);
    setreq(14, 3'h7);
    quiet("core_irq off or reserved");
    $display("priority test done");
  endtask : t_prio
  task automatic t_trap;
    @(posedge clk);
    setreq(0, 3'h7);
    trap_req <= 8'h24;
    take(7'h02, 24'h000008);
    chk("vec_level", vec_level, 4'h8);
    @(posedge clk);
    trap_req <= 8'he1;
    quiet("core_irq unused trap");
    chk("reset_pc", reset_pc, 24'h000000);
    $display("trap test done");
  endtask : t_trap
  task automatic t_alt;
    @(posedge clk);
    interrupt_control_two <= 16'h8000;
    setreq(65, 3'h6);
    take(7'h49, 24'h000196);
    @(posedge clk);
    trap_req <= 8'h02;
    take(7'h01, 24'h000106);
    @(posedge clk);
    interrupt_control_two <= 16'h7fff;
    setreq(65, 3'h6);
    take(7'h49, 24'h000096);
    $display("alternate test done");
  endtask : t_alt
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_map();
    t_prio();
    t_trap();
    t_alt();
    results();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    results();
  end
endmodule : test_interrupt_vector_controller
`default_nettype wire
